// *** adcsw_pkg.sv ***
`default_nettype none
package adcsw_pkg;
    // ==========================================
    // register map, byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] CFG_OFF = 8'h04;
    localparam logic [7:0] CLR_OFF = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
    // ==========================================
    // status word layout; the clear register shares it
    localparam int unsigned LOCK_BIT = 15;
    localparam int unsigned RESYNC_BIT = 14;
    localparam int unsigned REGMAP_BIT = 13;
    localparam int unsigned CRCERR_BIT = 12;
    localparam int unsigned CRCTYPE_BIT = 11;
    localparam int unsigned RSTFLAG_BIT = 10;
    localparam int unsigned WLEN_HI = 9;
    localparam int unsigned WLEN_LO = 8;
    localparam int unsigned RSV_HI = 7;
    localparam int unsigned RSV_LO = 4;
    localparam int unsigned NUM_CH = 4;
    localparam logic [3:0] RSV_VAL = 4'h0;
    // ==========================================
    // configuration register
    localparam int unsigned CFG_CRC_TYPE_BIT = 0;
    localparam int unsigned CFG_WLEN_LO = 1;
    localparam int unsigned CFG_WLEN_HI = 2;
    localparam logic CRC_TYPE_RST = 1'h0;
    localparam logic [1:0] WLEN_RST = 2'h1;
    localparam logic RSTFLAG_RST = 1'h1;
    // ==========================================
    // interrupt bits
    localparam int unsigned IRQ_RESYNC = 0;
    localparam int unsigned IRQ_REGMAP = 1;
    localparam int unsigned IRQ_CRCERR = 2;
    localparam int unsigned IRQ_DATA_LO = 3;
    localparam int unsigned IRQ_W = 7;
    // ==========================================
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** adcsw_sticky.sv ***
`timescale 1ns/1ps
`default_nettype none
// sticky flag: a set in the same cycle as a clear wins
module adcsw_sticky #(
    parameter logic RST_VAL = 1'h0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic set,
    input wire logic clr,
    output logic flag
);
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= RST_VAL;
        end else if (set) begin
            flag <= 1'h1;
        end else if (clr) begin
            flag <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// *** adcsw_axil_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsw_axil_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_held_ff;
    logic w_held_ff;

    // ==========================================
    // write path: address and data held until both are in
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
    assign wr_en = aw_held_ff && w_held_ff && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_ff <= 1'h0;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'h1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_held_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_ff <= 1'h0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'h1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_en) begin
            w_held_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= adcsw_pkg::RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= wr_ok ? adcsw_pkg::RESP_OKAY : adcsw_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
        end
    end

    // ==========================================
    // read path: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= adcsw_pkg::RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? adcsw_pkg::RESP_OKAY : adcsw_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// *** adcsw_status.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: bit 14 shows resync occurred, default 0
// R2: bit 13 flags register map crc change
// R3: bit 12 flags input frame crc error
// R4: bit 11 shows crc type, 0 ccitt
// R5: bit 10 reset flag, 1 after reset
// R6: bits 9:8 word length code, default 01
// R7: bits 7:4 always read zero
// R8: bit 3 channel 3 new data
// R9: bit 2 channel 2 new data
// R10: resync flag set on every resync
// R11: bit 15 shows interface lock state
// R12: writes to status word change nothing
module adcsw_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lock_state,
    input wire logic resync_event,
    input wire logic regmap_crc_change,
    input wire logic input_crc_error,
    input wire logic [3:0] conv_done,
    input wire logic [3:0] result_read,
    output logic crc_type_sel,
    output logic [1:0] word_length_code,
    output logic [15:0] status_word,
    output logic irq
);
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic resync_flag;
    logic regmap_flag;
    logic crc_err_flag;
    logic reset_flag;
    logic [3:0] new_data;
    logic ch3_new_data;
    logic ch2_new_data;
    logic wr_cfg;
    logic wr_clr;
    logic wr_istat;
    logic wr_imask;
    logic wr_status;
    logic [15:0] clr_bits;
    logic [adcsw_pkg::IRQ_W-1:0] irq_events;
    logic [adcsw_pkg::IRQ_W-1:0] irq_stat_ff;
    logic [adcsw_pkg::IRQ_W-1:0] irq_mask_ff;
    logic [adcsw_pkg::IRQ_W-1:0] irq_w1c;
    logic crc_type_ff;
    logic [1:0] wlen_ff;
    logic irq_ff;

    // ==========================================
    // bus slave
    adcsw_axil_slave u_bus (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ==========================================
    // write decode
    assign wr_status = wr_en && (wr_addr == adcsw_pkg::STATUS_OFF);
    assign wr_cfg = wr_en && (wr_addr == adcsw_pkg::CFG_OFF);
    assign wr_clr = wr_en && (wr_addr == adcsw_pkg::CLR_OFF);
    assign wr_istat = wr_en && (wr_addr == adcsw_pkg::IRQ_STAT_OFF);
    assign wr_imask = wr_en && (wr_addr == adcsw_pkg::IRQ_MASK_OFF);
    // the status word is mapped but read-only: its write is answered okay
    // and dropped, so a stray write never looks like a bus fault
    assign wr_ok = wr_status || wr_cfg || wr_clr || wr_istat || wr_imask; // [R12]

    // flag clears ride on byte lane 1 only, where those flags live
    assign clr_bits = (wr_clr && wr_strb[1]) ? wr_data[15:0] : 16'h0000;

    // ==========================================
    // configuration: steers the frame crc and word format logic
    always_ff @(posedge clk) begin
        if (rst) begin
            crc_type_ff <= adcsw_pkg::CRC_TYPE_RST; // [R4]
            wlen_ff <= adcsw_pkg::WLEN_RST; // [R6]
        end else if (wr_cfg && wr_strb[0]) begin
            crc_type_ff <= wr_data[adcsw_pkg::CFG_CRC_TYPE_BIT];
            wlen_ff <= wr_data[adcsw_pkg::CFG_WLEN_HI:adcsw_pkg::CFG_WLEN_LO];
        end
    end

    assign crc_type_sel = crc_type_ff;
    assign word_length_code = wlen_ff;

    // ==========================================
    // sticky status flags
    adcsw_sticky #(.RST_VAL(1'h0)) u_resync (
        .clk(clk),
        .rst(rst),
        .set(resync_event), // [R10]
        .clr(clr_bits[adcsw_pkg::RESYNC_BIT]),
        .flag(resync_flag)
    );

    adcsw_sticky #(.RST_VAL(1'h0)) u_regmap (
        .clk(clk),
        .rst(rst),
        .set(regmap_crc_change), // [R2]
        .clr(clr_bits[adcsw_pkg::REGMAP_BIT]),
        .flag(regmap_flag)
    );

    adcsw_sticky #(.RST_VAL(1'h0)) u_crcerr (
        .clk(clk),
        .rst(rst),
        .set(input_crc_error), // [R3]
        .clr(clr_bits[adcsw_pkg::CRCERR_BIT]),
        .flag(crc_err_flag)
    );

    // only a reset sets this flag; software clears it to spot the next one
    adcsw_sticky #(.RST_VAL(adcsw_pkg::RSTFLAG_RST)) u_rstflag (
        .clk(clk),
        .rst(rst),
        .set(1'h0),
        .clr(clr_bits[adcsw_pkg::RSTFLAG_BIT]), // [R5]
        .flag(reset_flag)
    );

    // new result flags drop when the result is read out
    for (genvar ch = 0; ch < adcsw_pkg::NUM_CH; ch++) begin : g_newdata
        adcsw_sticky #(.RST_VAL(1'h0)) u_nd (
            .clk(clk),
            .rst(rst),
            .set(conv_done[ch]), // [R8] [R9]
            .clr(result_read[ch]),
            .flag(new_data[ch])
        );
    end

    assign ch3_new_data = new_data[3];
    assign ch2_new_data = new_data[2];

    // ==========================================
    // status word assembly
    always_comb begin
        status_word = 16'h0000;
        status_word[adcsw_pkg::LOCK_BIT] = lock_state; // [R11]
        status_word[adcsw_pkg::RESYNC_BIT] = resync_flag; // [R1]
        status_word[adcsw_pkg::REGMAP_BIT] = regmap_flag; // [R2]
        status_word[adcsw_pkg::CRCERR_BIT] = crc_err_flag; // [R3]
        status_word[adcsw_pkg::CRCTYPE_BIT] = crc_type_ff; // [R4]
        status_word[adcsw_pkg::RSTFLAG_BIT] = reset_flag; // [R5]
        status_word[adcsw_pkg::WLEN_HI:adcsw_pkg::WLEN_LO] = wlen_ff; // [R6]
        status_word[adcsw_pkg::RSV_HI:adcsw_pkg::RSV_LO] = adcsw_pkg::RSV_VAL; // [R7]
        status_word[3] = ch3_new_data; // [R8]
        status_word[2] = ch2_new_data; // [R9]
        status_word[1:0] = new_data[1:0];
    end

    // ==========================================
    // interrupts
    assign irq_events = {conv_done, input_crc_error, regmap_crc_change, resync_event};
    assign irq_w1c = (wr_istat && wr_strb[0]) ? wr_data[adcsw_pkg::IRQ_W-1:0]
        : {adcsw_pkg::IRQ_W{1'h0}};

    // an event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_ff <= {adcsw_pkg::IRQ_W{1'h0}};
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_ff <= {adcsw_pkg::IRQ_W{1'h0}};
        end else if (wr_imask && wr_strb[0]) begin
            irq_mask_ff <= wr_data[adcsw_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'h0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign irq = irq_ff;

    // ==========================================
    // read mux; the clear register reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'h1;
        case (rd_addr)
            adcsw_pkg::STATUS_OFF: begin
                rd_data[15:0] = status_word;
            end
            adcsw_pkg::CFG_OFF: begin
                rd_data[adcsw_pkg::CFG_CRC_TYPE_BIT] = crc_type_ff;
                rd_data[adcsw_pkg::CFG_WLEN_HI:adcsw_pkg::CFG_WLEN_LO] = wlen_ff;
            end
            adcsw_pkg::CLR_OFF: begin
                rd_data = 32'h0000_0000;
            end
            adcsw_pkg::IRQ_STAT_OFF: begin
                rd_data[adcsw_pkg::IRQ_W-1:0] = irq_stat_ff;
            end
            adcsw_pkg::IRQ_MASK_OFF: begin
                rd_data[adcsw_pkg::IRQ_W-1:0] = irq_mask_ff;
            end
            default: begin
                rd_ok = 1'h0;
            end
        endcase
    end

    // ==========================================
    // assertions
    a_resync_set: assert property (@(posedge clk) disable iff (rst) // [R1]
        resync_event |=> status_word[adcsw_pkg::RESYNC_BIT])
        else $error("resync event not shown on status word");

    a_resync_hold: assert property (@(posedge clk) disable iff (rst) // [R10]
        status_word[adcsw_pkg::RESYNC_BIT] && !clr_bits[adcsw_pkg::RESYNC_BIT]
        |=> status_word[adcsw_pkg::RESYNC_BIT])
        else $error("resync flag dropped without a clear");

    a_regmap_set: assert property (@(posedge clk) disable iff (rst) // [R2]
        regmap_crc_change |=> status_word[adcsw_pkg::REGMAP_BIT])
        else $error("register map crc change not flagged");

    a_crcerr_set: assert property (@(posedge clk) disable iff (rst) // [R3]
        input_crc_error ##1 !input_crc_error[*2]
        |-> status_word[adcsw_pkg::CRCERR_BIT] || $past(clr_bits[adcsw_pkg::CRCERR_BIT]))
        else $error("input crc error flag lost");

    a_crc_type_cfg: assert property (@(posedge clk) disable iff (rst) // [R4]
        wr_cfg && wr_strb[0]
        |=> status_word[adcsw_pkg::CRCTYPE_BIT] == $past(wr_data[0]))
        else $error("crc type bit does not follow configuration");

    a_reset_defaults: assert property (@(posedge clk) // [R5]
        rst |=> status_word[adcsw_pkg::RSTFLAG_BIT]
            && status_word[adcsw_pkg::RESYNC_BIT:adcsw_pkg::CRCTYPE_BIT] == 4'h0)
        else $error("status word defaults wrong after reset");

    a_wlen_default: assert property (@(posedge clk) // [R6]
        rst |=> status_word[adcsw_pkg::WLEN_HI:adcsw_pkg::WLEN_LO] == 2'h1)
        else $error("word length code not 01 after reset");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // [R7]
        status_word[adcsw_pkg::RSV_HI:adcsw_pkg::RSV_LO] == 4'h0)
        else $error("reserved status bits not zero");

    a_ch3_flag: assert property (@(posedge clk) disable iff (rst) // [R8]
        (conv_done[3] |=> status_word[3])
        and (result_read[3] && !conv_done[3] |=> !status_word[3]))
        else $error("channel 3 new data flag wrong");

    a_ch2_clear: assert property (@(posedge clk) disable iff (rst) // [R9]
        result_read[2] && !conv_done[2] |=> !status_word[2])
        else $error("channel 2 new data flag not cleared");

    a_lock_shown: assert property (@(posedge clk) disable iff (rst) // [R11]
        status_word[adcsw_pkg::LOCK_BIT] == lock_state)
        else $error("lock bit does not follow lock state");

    a_ro_write: assert property (@(posedge clk) disable iff (rst) // [R12]
        wr_status |=> $stable(status_word[adcsw_pkg::CRCTYPE_BIT:adcsw_pkg::WLEN_LO])
            && s_axi_bresp == adcsw_pkg::RESP_OKAY)
        else $error("write to status word changed it");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        |(irq_stat_ff & irq_mask_ff) |=> irq)
        else $error("interrupt not raised for unmasked event");

    c_resync_clear: cover property (@(posedge clk) disable iff (rst)
        resync_flag ##[1:20] !resync_flag);

    c_reset_clear: cover property (@(posedge clk) disable iff (rst)
        wr_clr ##1 !reset_flag);

    c_irq_seen: cover property (@(posedge clk) disable iff (rst)
        irq ##[1:20] !irq);

    c_status_write: cover property (@(posedge clk) disable iff (rst)
        wr_status);
endmodule
`default_nettype wire

// *** adcsw_event_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// converter-side event source: registers a request word onto the event lines, one cycle late
module adcsw_event_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] req,
    output logic resync_event,
    output logic regmap_crc_change,
    output logic input_crc_error,
    output logic [3:0] conv_done,
    output logic [3:0] result_read
);
    // pulses are registered so they never share an edge with the request
    always_ff @(posedge clk) begin
        if (rst) begin
            {result_read, conv_done, input_crc_error, regmap_crc_change, resync_event} <= '0;
        end else begin
            resync_event <= req[0];
            regmap_crc_change <= req[1];
            input_crc_error <= req[2];
            conv_done <= req[7:4];
            result_read <= req[11:8];
        end
    end
endmodule
`default_nettype wire

// *** tb_adc_status_word.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_adc_status_word;
    logic clk, rst, lock_state, irq, crc_type_sel;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, wl, word_length_code;
    logic [15:0] status_word;
    logic [11:0] req;
    logic ev_rs, ev_rm, ev_ce, a, b;
    logic [3:0] ev_cd, ev_rr;
    logic [31:0] seed;
    int miscompares, checks;

    adcsw_event_src u_adcsw_event_src (.clk(clk), .rst(rst), .req(req),
        .resync_event(ev_rs), .regmap_crc_change(ev_rm), .input_crc_error(ev_ce),
        .conv_done(ev_cd), .result_read(ev_rr));

    adcsw_status u_adcsw_status (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lock_state(lock_state),
        .resync_event(ev_rs), .regmap_crc_change(ev_rm), .input_crc_error(ev_ce),
        .conv_done(ev_cd), .result_read(ev_rr), .crc_type_sel(crc_type_sel),
        .word_length_code(word_length_code), .status_word(status_word), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // expected status word from the individual flags
    function automatic logic [31:0] st(input logic lk, rs, rm, ce, ct, rf,
                                       input logic [1:0] wl, input logic [3:0] nd);
        return {16'h0, lk, rs, rm, ce, ct, rf, wl, 4'h0, nd};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ready is looked at where settled, the item moves at the following edge
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] sb);
        logic at, wt, bt;
        @(posedge clk);
        awaddr <= ad; awvalid <= 1'b1; wdata <= dt; wstrb <= sb; wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(negedge clk);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
            if (bt) begin
                bready <= 1'b0;
                return;
            end
        end
        miscompares++;
    endtask

    task automatic rd(input logic [7:0] ad);
        logic at, rt;
        @(posedge clk);
        araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(negedge clk);
            at = arvalid && arready;
            rt = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (at) arvalid <= 1'b0;
            if (rt) begin
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
    endtask

    task automatic ev(input logic [11:0] m);
        @(posedge clk);
        req <= m;
        @(posedge clk);
        req <= 12'h000;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        close_out();
    end

    initial begin
        miscompares = 0; checks = 0; seed = 32'h1ffe;
        rst = 1'b1; lock_state = 1'b0; req = 12'h000;
        awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 1, 2'h1, 4'h0));
        chk({30'h0, word_length_code}, 32'h1);
        lock_state <= 1'b1;
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(1, 0, 0, 0, 0, 1, 2'h1, 4'h0));
        lock_state <= 1'b0;
        wr(adcsw_pkg::STATUS_OFF, 32'hffffffff, 4'hf);
        chk({30'h0, r}, {30'h0, adcsw_pkg::RESP_OKAY});
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 1, 2'h1, 4'h0));
        wr(adcsw_pkg::CLR_OFF, 32'h00000400, 4'h2);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 0, 2'h1, 4'h0));
        ev(12'h001);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 1, 0, 0, 0, 0, 2'h1, 4'h0));
        wr(adcsw_pkg::CLR_OFF, 32'h00004000, 4'h2);
        ev(12'h001);
        ev(12'h006);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 1, 1, 1, 0, 0, 2'h1, 4'h0));
        wr(adcsw_pkg::CLR_OFF, 32'h00007000, 4'h2);
        ev(12'h0c0);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 0, 2'h1, 4'hc));
        ev(12'h800);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 0, 2'h1, 4'h4));
        // a new result in the same cycle as the read-out keeps the flag
        ev(12'h440);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 0, 2'h1, 4'h4));
        ev(12'h400);
        rd(adcsw_pkg::STATUS_OFF);
        chk(d, st(0, 0, 0, 0, 0, 0, 2'h1, 4'h0));
        // every configuration code first, then random ones
        for (int i = 0; i < 14; i++) begin
            seed = xs(seed);
            lock_state <= seed[3];
            wr(adcsw_pkg::CFG_OFF, (i < 8) ? i : {29'h0, seed[2:0]}, 4'hf);
            if (i >= 8) d = {29'h0, seed[2:0]};
            else d = i;
            a = seed[3];
            b = d[0];
            wl = d[2:1];
            rd(adcsw_pkg::STATUS_OFF);
            chk(d, st(a, 0, 0, 0, b, 0, wl, 4'h0));
            chk({16'h0, status_word}, st(a, 0, 0, 0, b, 0, wl, 4'h0));
            chk({29'h0, word_length_code, crc_type_sel}, {29'h0, wl, b});
        end
        // interrupt: clear, enable/disable by mask, raise, acknowledge
        wr(adcsw_pkg::IRQ_STAT_OFF, 32'h7f, 4'hf);
        rd(adcsw_pkg::IRQ_STAT_OFF);
        chk(d, 32'h0);
        wr(adcsw_pkg::IRQ_MASK_OFF, 32'h7f, 4'hf);
        ev(12'h001);
        // irq is launched by the edge that ends ev, so look half a cycle later
        @(negedge clk);
        a = irq;
        wr(adcsw_pkg::IRQ_MASK_OFF, 32'h0, 4'hf);
        repeat (2) @(negedge clk);
        b = irq;
        chk({31'h0, a}, 32'h1);
        chk({31'h0, b}, 32'h0);
        rd(adcsw_pkg::IRQ_STAT_OFF);
        chk(d, 32'h1 << adcsw_pkg::IRQ_RESYNC);
        // unmask again so the acknowledge below really has to drop irq
        wr(adcsw_pkg::IRQ_MASK_OFF, 32'h7f, 4'hf);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(adcsw_pkg::IRQ_STAT_OFF, 32'h7f, 4'hf);
        repeat (2) @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(8'h20);
        chk({30'h0, r}, {30'h0, adcsw_pkg::RESP_SLVERR});
        chk(d, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
